// ### hdl/bcr_pkg.sv
package bcr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_BEACON_CTRL = 8'h25;
  localparam logic [7:0] IDX_GATED_CLK   = 8'h26;
  localparam logic [7:0] IDX_TURNAROUND  = 8'h27;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'h30;
  localparam logic [7:0] IDX_IRQ_MASK    = 8'h31;

  // Beacon control field positions
  localparam int BIT_BEACON_MASK = 7;
  localparam int BIT_WAKE_SRC    = 6;
  localparam int BIT_AVG_HI      = 5;
  localparam int BIT_AVG_LO      = 4;
  // Gated clock field position
  localparam int BIT_SLOT_CLK_EN = 3;
  // Turnaround field positions
  localparam int BIT_TURN_HI     = 7;
  localparam int BIT_TURN_LO     = 4;
  // Interrupt status and mask positions
  localparam int BIT_IRQ_BEACON  = 0;
  localparam int BIT_IRQ_WAKE    = 1;
  localparam int IRQ_W           = 2;

  // Reset values and turnaround minimum
  localparam logic [1:0] RST_AVG_COUNT = 2'h3;
  localparam logic [7:0] RST_TURNAROUND = 8'h48;
  localparam logic [3:0] TURN_MIN       = 4'h2;

  // Averaging encodings
  localparam logic [1:0] AVG_ONE   = 2'h0;
  localparam logic [1:0] AVG_TWO   = 2'h1;
  localparam logic [1:0] AVG_FOUR  = 2'h2;
  localparam logic [1:0] AVG_EIGHT = 2'h3;

  // Timing
  localparam int CLK_PERIOD_NS     = 8;
  localparam int SYMBOL_NS         = 16000;
  localparam int SYMBOL_CYCLES     = SYMBOL_NS / CLK_PERIOD_NS;

  // AHB transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ### hdl/bcr_regs.sv
// Function
// - Beacon FIFO interrupt blocked while mask bit 7 is one; default zero.
// - Read-only bit 6 shows last wake cause: 1 beacon start, 0 wake-up.
// - Bits 5-4 pick averaging: 11 eight, 10 four, 01 two, 00 one.
// - Slot FIFO clock enabled only while gated clock bit 3 is one.
// - Turnaround upper nibble in 16 us symbols, default 4, minimum 2.
//
// Our own choice: register access over AHB-Lite.
module bcr_regs (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Events from MAC logic, one-cycle pulses
  input  wire logic        beacon_fifo_event,
  input  wire logic        wake_beacon_start,
  input  wire logic        wake_wakeup,
  // Controls to the MAC
  output logic             beacon_fifo_irq,
  output logic      [1:0]  signal_strength_avg_count,
  output logic      [3:0]  avg_symbols,
  output logic             slot_fifo_clock_enable,
  output logic      [3:0]  rx_tx_turnaround,
  output logic      [14:0] turnaround_cycles,
  // Interrupt
  output logic             irq
);

  // Register state
  logic              beacon_fifo_irq_mask_r;
  logic              wake_source_flag_r;
  logic [1:0]        avg_count_r;
  logic              slot_clk_en_r;
  logic [7:0]        turnaround_r;
  logic [1:0]        irq_mask_r;
  logic [1:0]        irq_status;
  logic [1:0]        irq_set;
  logic [1:0]        irq_clr;
  // Bus data phase state
  logic              wr_pend_r;
  logic              rd_pend_r;
  logic [7:0]        idx_r;
  logic              addr_ok;
  logic              take;
  logic [3:0]        turn_eff;
  logic [3:0]        turn_raw;
  // Per-register write strobes, live for one data phase cycle
  logic              wr_beacon;
  logic              wr_gate;
  logic              wr_turn;
  logic              wr_mask;
  logic              wr_status;

  // Address phase accepted on a live selected NONSEQ
  assign take    = hsel && hready && (htrans == bcr_pkg::HTRANS_NONSEQ);
  assign addr_ok = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);

  // One strobe per register, decoded once from the latched index.
  // Every storage process below then reduces to a plain enable, and an
  // unmapped or misaligned address simply raises no strobe at all, so
  // such a write is dropped without any special case in the registers.
  assign wr_beacon = wr_pend_r && (idx_r == bcr_pkg::IDX_BEACON_CTRL);
  assign wr_gate   = wr_pend_r && (idx_r == bcr_pkg::IDX_GATED_CLK);
  assign wr_turn   = wr_pend_r && (idx_r == bcr_pkg::IDX_TURNAROUND);
  assign wr_mask   = wr_pend_r && (idx_r == bcr_pkg::IDX_IRQ_MASK);
  assign wr_status = wr_pend_r && (idx_r == bcr_pkg::IDX_IRQ_STATUS);

  // Latch address phase for the data phase that follows.
  // The latch only moves while hready is high, so a stalled bus keeps
  // the pending transfer intact; this slave never stalls, but another
  // slave on a shared bus might, and the data phase must then wait.
  // Misaligned or out-of-range addresses never raise a pending flag.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      idx_r     <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= take && hwrite && addr_ok;
      rd_pend_r <= take && !hwrite && addr_ok;
      idx_r     <= haddr[9:2];
    end
  end

  // Zero wait state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Beacon control: mask and averaging writable, wake flag is not.
  // Write data is taken in the data phase cycle, so the new value is
  // visible from the edge that ends that cycle. The reserved low
  // nibble is not stored; it always reads back as zero.
  // Averaging resets to the longest window, eight symbols.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      beacon_fifo_irq_mask_r <= 1'b0;
      avg_count_r            <= bcr_pkg::RST_AVG_COUNT;
    end else if (wr_beacon) begin
      beacon_fifo_irq_mask_r <= hwdata[bcr_pkg::BIT_BEACON_MASK];
      avg_count_r <= hwdata[bcr_pkg::BIT_AVG_HI:bcr_pkg::BIT_AVG_LO];
    end
  end

  // Wake cause follows hardware only; beacon start wins a tie.
  // No bus write reaches this flop, which is what makes the flag
  // read-only: software can never mask the true cause of a wake.
  // Without either event the flag holds the cause of the last wake.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_source_flag_r <= 1'b0;
    end else if (wake_beacon_start) begin
      wake_source_flag_r <= 1'b1;
    end else if (wake_wakeup) begin
      wake_source_flag_r <= 1'b0;
    end
  end

  // Gated clock enable; reserved bits are not stored.
  // Reset leaves the slot FIFO clock stopped so those FIFOs draw no
  // power until software asks for them.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot_clk_en_r <= 1'b0;
    end else if (wr_gate) begin
      slot_clk_en_r <= hwdata[bcr_pkg::BIT_SLOT_CLK_EN];
    end
  end

  // Turnaround kept whole so the reserved nibble reads back as written.
  // Storing the low nibble costs four flops but lets software check
  // that it has kept the reserved value it was asked to keep.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      turnaround_r <= bcr_pkg::RST_TURNAROUND;
    end else if (wr_turn) begin
      turnaround_r <= hwdata[7:0];
    end
  end

  // Interrupt mask register, same layout as the status register.
  // A one here lets the matching status bit drive the irq line; reset
  // keeps every source quiet until software opts in.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_r <= 2'h0;
    end else if (wr_mask) begin
      irq_mask_r <= hwdata[1:0];
    end
  end

  // Beacon FIFO interrupt passes only when unmasked.
  // Kept combinational so the pulse keeps the timing of its event.
  assign beacon_fifo_irq = beacon_fifo_event &&
                           !beacon_fifo_irq_mask_r;

  // Event sources for sticky status.
  // A masked beacon event leaves no trace in status either, so
  // unmasking later does not raise a stale interrupt.
  always_comb begin
    irq_set = 2'h0;
    irq_set[bcr_pkg::BIT_IRQ_BEACON] = beacon_fifo_irq;
    irq_set[bcr_pkg::BIT_IRQ_WAKE]   = wake_beacon_start || wake_wakeup;
  end

  // Write one to clear; zeros in the write leave their bits alone,
  // so software can clear one source without racing the other
  assign irq_clr = wr_status ? hwdata[1:0] : 2'h0;

  // Sticky status flags; set beats clear inside the flag module

  bcr_sticky #(
    .W (bcr_pkg::IRQ_W)
  ) u_status (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set_in  (irq_set),
    .clr_in  (irq_clr),
    .flag_r  (irq_status)
  );

  // Level interrupt while any unmasked status bit is set.
  // A level rather than a pulse cannot be lost if the receiver is slow.
  assign irq = |(irq_status & irq_mask_r);

  // Read mux of flops in data phase, so a read after a write sees it.
  // Outside a read data phase the bus shows zero, which keeps hrdata
  // quiet and makes a stray sample harmless. Unmapped indices read 0.
  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_pend_r) begin
      case (idx_r)
        bcr_pkg::IDX_BEACON_CTRL: begin
          hrdata[bcr_pkg::BIT_BEACON_MASK] = beacon_fifo_irq_mask_r;
          hrdata[bcr_pkg::BIT_WAKE_SRC]    = wake_source_flag_r;
          hrdata[bcr_pkg::BIT_AVG_HI:bcr_pkg::BIT_AVG_LO] = avg_count_r;
        end
        bcr_pkg::IDX_GATED_CLK: begin
          hrdata[bcr_pkg::BIT_SLOT_CLK_EN] = slot_clk_en_r;
        end
        bcr_pkg::IDX_TURNAROUND: begin
          hrdata[7:0] = turnaround_r;
        end
        bcr_pkg::IDX_IRQ_STATUS: begin
          hrdata[1:0] = irq_status;
        end
        bcr_pkg::IDX_IRQ_MASK: begin
          hrdata[1:0] = irq_mask_r;
        end
        default: begin
          hrdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Averaging length decode into a plain symbol count.
  // The default branch only covers unknown values in simulation.
  always_comb begin
    case (avg_count_r)
      bcr_pkg::AVG_EIGHT: avg_symbols = 4'h8;
      bcr_pkg::AVG_FOUR:  avg_symbols = 4'h4;
      bcr_pkg::AVG_TWO:   avg_symbols = 4'h2;
      bcr_pkg::AVG_ONE:   avg_symbols = 4'h1;
      default:            avg_symbols = 4'h1;
    endcase
  end

  // Register fields straight to the MAC
  assign signal_strength_avg_count = avg_count_r;
  assign slot_fifo_clock_enable    = slot_clk_en_r;

  // Raw nibble as software stored it
  assign turn_raw = turnaround_r[bcr_pkg::BIT_TURN_HI:bcr_pkg::BIT_TURN_LO];

  // Too short a value would break turnaround, so it is held at the floor.
  // The stored value is left alone so software reads back what it wrote;
  // only the copy handed to the timing engine is clamped.
  always_comb begin
    if (turn_raw < bcr_pkg::TURN_MIN) begin
      turn_eff = bcr_pkg::TURN_MIN;
    end else begin
      turn_eff = turn_raw;
    end
  end

  // Symbol count and its length in clock cycles for the timing engine.
  // Fifteen bits hold the largest setting, fifteen symbols of cycles.
  assign rx_tx_turnaround  = turn_eff;
  assign turnaround_cycles = 15'(turn_eff * bcr_pkg::SYMBOL_CYCLES);

endmodule // bcr_regs

// ### hdl/bcr_sticky.sv
// Sticky flags, set by hardware, cleared by software write of one
module bcr_sticky #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Set and clear vectors
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clr_in,
  // Flag state
  output logic      [W-1:0] flag_r
);

  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_r <= '0;
    end else begin
      flag_r <= (flag_r & ~clr_in) | set_in;
    end
  end

endmodule // bcr_sticky

// ### tb/bcr_properties.sv
module bcr_properties (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Watched ports
  input wire logic        beacon_fifo_event,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        beacon_fifo_irq,
  input wire logic [1:0]  signal_strength_avg_count,
  input wire logic [3:0]  avg_symbols,
  input wire logic        slot_fifo_clock_enable,
  input wire logic [3:0]  rx_tx_turnaround,
  input wire logic [14:0] turnaround_cycles
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // The interrupt may only pass an event through, never invent one
  a_irq_needs_event:
    assert property (beacon_fifo_irq |-> beacon_fifo_event)
    else $error("beacon irq without event");
  a_avg_decode:
    assert property (avg_symbols == (4'h1 << signal_strength_avg_count))
    else $error("averaging decode wrong");
  a_slot_clk_off:
    assert property ($rose(hresetn) |-> !slot_fifo_clock_enable)
    else $error("slot clock on after reset");
  // Clamp guards the turnaround engine against a too short setting
  a_turn_floor:
    assert property (rx_tx_turnaround >= 4'h2)
    else $error("turnaround below floor");
  a_turn_cycles:
    assert property (turnaround_cycles == 15'(rx_tx_turnaround) * 15'h07D0)
    else $error("turnaround cycles wrong");
  // Zero wait state slave that always answers OKAY
  a_bus_okay:
    assert property (hreadyout && !hresp)
    else $error("bus not ready or error response");
endmodule // bcr_properties

// ### tb/tb_bcr_regs.sv
module tb_bcr_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [2:0]  ev = 3'h0;
  logic        hready, hresp, bfi, sce, irq;
  logic [31:0] hrdata, q;
  logic [1:0]  sac;
  logic [3:0]  avs, rtt;
  logic [14:0] tcy;
  int          n_mismatch = 0;
  int          check_count = 0;

  // Clock at 125 MHz
  always #4 hclk = ~hclk;

  bcr_regs u_bcr_regs (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .beacon_fifo_event(ev[2]), .wake_beacon_start(ev[1]),
    .wake_wakeup(ev[0]), .beacon_fifo_irq(bfi),
    .signal_strength_avg_count(sac), .avg_symbols(avs),
    .slot_fifo_clock_enable(sce), .rx_tx_turnaround(rtt),
    .turnaround_cycles(tcy), .irq(irq));

  task automatic results;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Bounded wait for ready sampled at a falling edge; a hang ends the run
  task automatic rdy;
    int n;
    logic r;
    n = 0;
    do begin
      @(negedge hclk);
      r = hready;
      q = hrdata;
      @(posedge hclk);
      n++;
    end while (r !== 1'b1 && n < 64);
    if (r !== 1'b1) begin
      n_mismatch++;
      results();
    end
  endtask

  // Single word transfer; returns just after the edge so updates land
  task automatic xfer(input logic [7:0] i, input logic w,
                      input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= 32'(i) << 2;
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    #1;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    xfer(i, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    xfer(i, 1'b0, 32'h0000_0000);
    chk(q, e);
  endtask

  // One-cycle event pulse, beacon irq looked at inside the pulse
  task automatic pulse(input logic [2:0] p, input logic e);
    ev <= p;
    #1 chk(32'(bfi), 32'(e));
    @(posedge hclk);
    ev <= 3'h0;
    @(posedge hclk);
    #1;
  endtask

  task automatic t_reset;
    rd(8'h25, 32'h0000_0030);
    rd(8'h26, 32'h0000_0000);
    rd(8'h27, 32'h0000_0048);
    chk(32'({sce, avs, rtt, tcy}), 32'({1'b0, 4'h8, 4'h4, 15'h1F40}));
  endtask

  task automatic t_avg;
    for (int c = 0; c < 4; c++) begin
      wr(8'h25, 32'h0000_0040 | (32'(c) << 4));
      rd(8'h25, 32'(c) << 4);
      chk(32'({sac, avs}), 32'({2'(c), 4'h1 << c}));
    end
  endtask

  task automatic t_irq;
    wr(bcr_pkg::IDX_IRQ_MASK, 32'h0000_0001);
    pulse(3'h4, 1'b1);
    rd(bcr_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001);
    wr(bcr_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    wr(8'h25, 32'h0000_00B0);
    pulse(3'h4, 1'b0);
    rd(bcr_pkg::IDX_IRQ_STATUS, 32'h0000_0000);
  endtask

  // Wake cause, then a write that tries to overturn it
  task automatic t_wake;
    pulse(3'h2, 1'b0);
    rd(8'h25, 32'h0000_00F0);
    chk(32'(irq), 32'h0000_0000);
    pulse(3'h1, 1'b0);
    rd(8'h25, 32'h0000_00B0);
    pulse(3'h3, 1'b0);
    rd(8'h25, 32'h0000_00F0);
    wr(8'h25, 32'h0000_0030);
    rd(8'h25, 32'h0000_0070);
    rd(bcr_pkg::IDX_IRQ_STATUS, 32'h0000_0002);
  endtask

  task automatic t_gate_turn;
    wr(8'h26, 32'h0000_0008);
    chk(32'(sce), 32'h0000_0001);
    rd(8'h26, 32'h0000_0008);
    wr(8'h26, 32'h0000_0000);
    chk(32'(sce), 32'h0000_0000);
    wr(8'h27, 32'h0000_0038);
    chk(32'({rtt, tcy}), 32'({4'h3, 15'h1770}));
    wr(8'h27, 32'h0000_0018);
    rd(8'h27, 32'h0000_0018);
    chk(32'({rtt, tcy}), 32'({4'h2, 15'h0FA0}));
    wr(8'h40, 32'h0000_00FF);
    rd(8'h40, 32'h0000_0000);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_avg();
    t_irq();
    t_wake();
    t_gate_turn();
    results();
  end
endmodule // tb_bcr_regs

bind bcr_regs bcr_properties u_bcr_properties (
  .hclk(hclk), .hresetn(hresetn), .beacon_fifo_event(beacon_fifo_event),
  .hreadyout(hreadyout), .hresp(hresp),
  .beacon_fifo_irq(beacon_fifo_irq),
  .signal_strength_avg_count(signal_strength_avg_count),
  .avg_symbols(avg_symbols), .slot_fifo_clock_enable(slot_fifo_clock_enable),
  .rx_tx_turnaround(rx_tx_turnaround), .turnaround_cycles(turnaround_cycles));
